// ==== crr_pkg.sv ====
// package: register map, field layout and carrier types for the conversion result bank
package crr_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int RES_W = 24;
   localparam int NUM_CH = 16;
   localparam int CH_W = 4;
   localparam int ERR_W = 8;
   localparam int GPIO_W = 4;

   localparam logic [ADDR_W-1:0] OFF_RESULT_STATUS = 8'h20;
   localparam logic [ADDR_W-1:0] OFF_CH_RESULT_FIRST = 8'h28;
   localparam logic [ADDR_W-1:0] OFF_CH_RESULT_LAST = 8'h64;
   localparam logic [ADDR_W-1:0] OFF_CH_RESULT_STEP = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_PIN_FUNCTION = 8'h68;
   localparam logic [ADDR_W-1:0] OFF_CONFIG = 8'h70;
   localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h74;
   localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h78;
   localparam logic [ADDR_W-1:0] OFF_ERR_ENABLE = 8'h7c;

   localparam logic [7:0] STATUS_RESET = 8'h60;
   localparam int ST_ERR_BIT = 7;
   localparam int ST_RST_BIT = 6;
   localparam int ST_RDY_BIT = 5;
   localparam int ST_FIR_BIT = 4;
   localparam int ST_CH_LSB = 0;
   localparam int RES_LSB = 8;

   localparam logic [15:0] PIN_FUNC_RESET = 16'h0004;
   // writable fields: bit 14 plus the low byte; bits 15 and 13:8 reserved
   localparam logic [15:0] PIN_FUNC_WMASK = 16'h40ff;
   localparam int PF_CHAN_PINS_BIT = 14;

   localparam int CFG_SHARED_BIT = 0;
   localparam int CFG_PERCH_BIT = 1;
   localparam int CFG_FIR_BIT = 2;
   localparam int CFG_OVERRIDE_BIT = 3;

   localparam int IRQ_W = 3;
   localparam int IRQ_CONV_BIT = 0;
   localparam int IRQ_RESET_BIT = 1;
   localparam int IRQ_ERR_BIT = 2;

   typedef struct packed {
      logic [ADDR_W-1:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [DATA_W-1:0] pwdata;
   } crr_apb_req_t;

   typedef struct packed {
      logic [DATA_W-1:0] prdata;
      logic pready;
      logic pslverr;
   } crr_apb_rsp_t;

   typedef struct packed {
      logic valid;
      logic [CH_W-1:0] channel;
      logic [RES_W-1:0] data;
      logic settled;
   } crr_conv_t;
endpackage : crr_pkg

// ==== crr_result_mem.sv ====
// per-channel result storage with registered read port
`timescale 1ns/1ps
module crr_result_mem #(
   parameter int DEPTH = 16,
   parameter int WIDTH = 24,
   parameter int AW = 4
) (
   input wire logic clock, // 200 MHz clock
   input wire logic rst_n, // synchronous reset, active low
   input wire logic we, // write strobe
   input wire logic [AW-1:0] waddr, // write index
   input wire logic [WIDTH-1:0] wdata, // write data
   input wire logic [AW-1:0] raddr, // read index
   output logic [WIDTH-1:0] rdata // registered read data
);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [WIDTH-1:0] rd;
   } crr_mem_state_t;

   crr_mem_state_t state_reg;
   crr_mem_state_t state_next;

   always_comb begin
      state_next = state_reg;
      state_next.rd = state_reg.mem[raddr];
      if (we) begin
         state_next.mem[waddr] = wdata;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign rdata = state_reg.rd;
endmodule : crr_result_mem

// ==== crr_pin_drive.sv ====
// general-purpose pin arbitration between other pin functions and channel number
`timescale 1ns/1ps
module crr_pin_drive #(
   parameter int W = 4
) (
   input wire logic clock, // 200 MHz clock
   input wire logic rst_n, // synchronous reset, active low
   input wire logic chan_enable, // channel number on pins enabled
   input wire logic [W-1:0] channel, // current channel number
   input wire logic [W-1:0] other_oe, // other function claims pin
   input wire logic [W-1:0] other_out, // other function drive level
   output logic [W-1:0] pin_out, // pin output level, registered
   output logic [W-1:0] pin_oe // pin output enable, registered
);
   typedef struct packed {
      logic [W-1:0] out;
      logic [W-1:0] oe;
   } crr_pin_state_t;

   crr_pin_state_t state_reg;
   crr_pin_state_t state_next;

   always_comb begin
      state_next = state_reg;
      for (int i = 0; i < W; i++) begin
         // another function holding a pin wins over the channel number
         if (other_oe[i]) begin
            state_next.oe[i] = 1'b1;
            state_next.out[i] = other_out[i];
         end else if (chan_enable) begin
            state_next.oe[i] = 1'b1;
            state_next.out[i] = channel[i];
         end else begin
            state_next.oe[i] = 1'b0;
            state_next.out[i] = 1'b0;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign pin_out = state_reg.out;
   assign pin_oe = state_reg.oe;
endmodule : crr_pin_drive

// ==== crr_result_regs.sv ====
// conversion result register bank with APB slave, interrupts and pin drive
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
// Function
// - 32-bit result word: result in 31:8, status in 7:0, reset 0x60.
// - Result word sits at byte addresses 0x20 to 0x23, little endian.
// - Result word valid only while all channels share one data register; config bit 3 (override) also shows it outside shared mode.
// - Status bit 7 high while any enabled error flag is set.
// - Status bit 6 set by any reset, resets high, write one clears.
// - Status bit 5 follows conversion-ready, read-only, one after reset.
// - Status bit 4 low until FIR output settles, then high.
// - Status bits 3:0 give channel of the previous result.
// - Sixteen channel result words from 0x28 to 0x64, step four.
// - With per-channel mode on, each result goes to its channel word.
// - Channel words hold read-only 24-bit result, reset zero.
// - Pin-function register 16 bits at 0x68, reset 0x0004.
// - Any pin-function write resets filter, control logic and sequencer.
// - Bit 14 set drives channel number on four pins, pin 3 msb.
// - Bit 14 clear leaves the channel number off the pins.
// - Other pin functions take precedence over the channel number.
module crr_result_regs (
   input wire logic clock, // 200 MHz clock
   input wire logic rst_n, // synchronous reset, active low
   input wire crr_pkg::crr_apb_req_t apb_req, // apb request
   output crr_pkg::crr_apb_rsp_t apb_rsp, // apb response
   input wire crr_pkg::crr_conv_t conv, // conversion result strobe
   input wire logic conv_ready, // conversion-ready indicator level
   input wire logic [crr_pkg::ERR_W-1:0] error_flags, // raw error flags
   input wire logic reset_event, // register or sequence reset pulse
   input wire logic [crr_pkg::GPIO_W-1:0] other_pin_oe, // other function owns pin
   input wire logic [crr_pkg::GPIO_W-1:0] other_pin_out, // other function level
   input wire logic [crr_pkg::CH_W-1:0] current_channel, // channel being converted
   output logic filter_reset, // one-cycle pulse to filter, control, sequencer
   output logic [crr_pkg::GPIO_W-1:0] gpio_out, // pin levels
   output logic [crr_pkg::GPIO_W-1:0] gpio_oe, // pin output enables
   output logic irq // level interrupt
);
   typedef enum logic [2:0] {
      BUS_IDLE = 3'b001,
      BUS_WAIT = 3'b010,
      BUS_DONE = 3'b100
   } crr_bus_state_t;

   typedef struct packed {
      crr_bus_state_t bus;
      logic [crr_pkg::RES_W-1:0] result;
      logic rst_flag;
      logic settled;
      logic [crr_pkg::CH_W-1:0] last_ch;
      logic [15:0] pin_func;
      logic [3:0] config_bits;
      logic [crr_pkg::ERR_W-1:0] err_enable;
      logic [crr_pkg::IRQ_W-1:0] irq_status;
      logic [crr_pkg::IRQ_W-1:0] irq_mask;
      logic [crr_pkg::DATA_W-1:0] rdata;
      logic slverr;
      logic frst;
      logic rdy_d;
   } crr_state_t;

   crr_state_t state_reg;
   crr_state_t state_next;
   logic [crr_pkg::RES_W-1:0] mem_rdata;
   logic mem_we;
   logic [crr_pkg::CH_W-1:0] mem_raddr;
   logic err_summary;
   logic shared_mode;

   function automatic logic is_ch_addr(input logic [crr_pkg::ADDR_W-1:0] a);
      return (a >= crr_pkg::OFF_CH_RESULT_FIRST) && (a <= crr_pkg::OFF_CH_RESULT_LAST)
         && (a[1:0] == 2'b00);
   endfunction : is_ch_addr

   function automatic logic [crr_pkg::CH_W-1:0] ch_index(input logic [crr_pkg::ADDR_W-1:0] a);
      logic [crr_pkg::ADDR_W-1:0] d;
      d = (a - crr_pkg::OFF_CH_RESULT_FIRST) >> 2;
      return d[crr_pkg::CH_W-1:0];
   endfunction : ch_index

   // override lets software see the result word outside shared mode, for bring-up
   assign shared_mode = state_reg.config_bits[crr_pkg::CFG_SHARED_BIT]
      | state_reg.config_bits[crr_pkg::CFG_OVERRIDE_BIT];
   assign err_summary = |(error_flags & state_reg.err_enable);
   assign mem_we = conv.valid && state_reg.config_bits[crr_pkg::CFG_PERCH_BIT];
   assign mem_raddr = ch_index(apb_req.paddr);

   crr_result_mem #(
      .DEPTH(crr_pkg::NUM_CH),
      .WIDTH(crr_pkg::RES_W),
      .AW(crr_pkg::CH_W)
   ) u_mem (
      .clock(clock),
      .rst_n(rst_n),
      .we(mem_we),
      .waddr(conv.channel),
      .wdata(conv.data),
      .raddr(mem_raddr),
      .rdata(mem_rdata)
   );

   crr_pin_drive #(
      .W(crr_pkg::GPIO_W)
   ) u_pins (
      .clock(clock),
      .rst_n(rst_n),
      .chan_enable(state_reg.pin_func[crr_pkg::PF_CHAN_PINS_BIT]),
      .channel(current_channel),
      .other_oe(other_pin_oe),
      .other_out(other_pin_out),
      .pin_out(gpio_out),
      .pin_oe(gpio_oe)
   );

   always_comb begin
      logic wr;
      logic [7:0] status;
      logic [crr_pkg::IRQ_W-1:0] ev;
      logic [crr_pkg::IRQ_W-1:0] w1c;
      wr = 1'b0;
      status = '0;
      ev = '0;
      w1c = '0;
      state_next = state_reg;
      state_next.frst = 1'b0;
      state_next.rdy_d = conv_ready;

      // conversion capture into the shared result word
      if (conv.valid && state_reg.config_bits[crr_pkg::CFG_SHARED_BIT]) begin
         state_next.result = conv.data;
      end
      if (conv.valid) begin
         state_next.last_ch = conv.channel;
         // without the FIR the settled bit carries no meaning and each conversion sets it high
         state_next.settled = conv.settled
            | ~state_reg.config_bits[crr_pkg::CFG_FIR_BIT];
         ev[crr_pkg::IRQ_CONV_BIT] = 1'b1;
      end
      ev[crr_pkg::IRQ_ERR_BIT] = err_summary;
      ev[crr_pkg::IRQ_RESET_BIT] = reset_event;

      status[crr_pkg::ST_ERR_BIT] = err_summary;
      status[crr_pkg::ST_RST_BIT] = state_reg.rst_flag;
      status[crr_pkg::ST_RDY_BIT] = state_reg.rdy_d;
      status[crr_pkg::ST_FIR_BIT] = state_reg.settled;
      status[crr_pkg::ST_CH_LSB +: crr_pkg::CH_W] = state_reg.last_ch;

      case (state_reg.bus)
         BUS_IDLE: begin
            if (apb_req.psel && !apb_req.penable) begin
               state_next.bus = BUS_WAIT;
            end
         end
         BUS_WAIT: begin
            // one wait cycle lets the result memory present its registered data
            state_next.bus = BUS_DONE;
            state_next.slverr = 1'b0;
            if (apb_req.pwrite) begin
               // read data is left alone so prdata holds until the next read
               wr = 1'b1;
            end else begin
               state_next.rdata = '0;
               // reads only fetch; no flag is touched by a read
               if (apb_req.paddr == crr_pkg::OFF_RESULT_STATUS) begin
                  if (shared_mode) begin
                     state_next.rdata = {state_reg.result, status};
                  end else begin
                     state_next.rdata = {{crr_pkg::RES_W{1'b0}}, status};
                  end
               end else if (is_ch_addr(apb_req.paddr)) begin
                  state_next.rdata = {8'h00, mem_rdata};
               end else if (apb_req.paddr == crr_pkg::OFF_PIN_FUNCTION) begin
                  state_next.rdata = {16'h0000, state_reg.pin_func};
               end else if (apb_req.paddr == crr_pkg::OFF_CONFIG) begin
                  state_next.rdata = {28'h0000000, state_reg.config_bits};
               end else if (apb_req.paddr == crr_pkg::OFF_IRQ_STATUS) begin
                  state_next.rdata = {29'h00000000, state_reg.irq_status};
               end else if (apb_req.paddr == crr_pkg::OFF_IRQ_MASK) begin
                  state_next.rdata = {29'h00000000, state_reg.irq_mask};
               end else if (apb_req.paddr == crr_pkg::OFF_ERR_ENABLE) begin
                  state_next.rdata = {24'h000000, state_reg.err_enable};
               end else begin
                  state_next.slverr = 1'b1;
               end
            end
         end
         BUS_DONE: begin
            state_next.bus = BUS_IDLE;
            state_next.slverr = 1'b0;
         end
         default: begin
            state_next.bus = BUS_IDLE;
         end
      endcase

      if (wr) begin
         if (apb_req.paddr == crr_pkg::OFF_RESULT_STATUS) begin
            if (apb_req.pwdata[crr_pkg::ST_RST_BIT]) begin
               state_next.rst_flag = 1'b0;
            end
         end else if (apb_req.paddr == crr_pkg::OFF_PIN_FUNCTION) begin
            state_next.pin_func = apb_req.pwdata[15:0] & crr_pkg::PIN_FUNC_WMASK;
            state_next.frst = 1'b1;
         end else if (apb_req.paddr == crr_pkg::OFF_CONFIG) begin
            state_next.config_bits = apb_req.pwdata[3:0];
         end else if (apb_req.paddr == crr_pkg::OFF_IRQ_STATUS) begin
            w1c = apb_req.pwdata[crr_pkg::IRQ_W-1:0];
         end else if (apb_req.paddr == crr_pkg::OFF_IRQ_MASK) begin
            state_next.irq_mask = apb_req.pwdata[crr_pkg::IRQ_W-1:0];
         end else if (apb_req.paddr == crr_pkg::OFF_ERR_ENABLE) begin
            state_next.err_enable = apb_req.pwdata[crr_pkg::ERR_W-1:0];
         end else if (!is_ch_addr(apb_req.paddr)) begin
            state_next.slverr = 1'b1;
         end
      end

      // set wins over a clear in the same cycle
      if (reset_event) begin
         state_next.rst_flag = 1'b1;
      end
      state_next.irq_status = (state_reg.irq_status & ~w1c) | ev;
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state_reg <= '0;
         state_reg.bus <= BUS_IDLE;
         state_reg.rst_flag <= crr_pkg::STATUS_RESET[crr_pkg::ST_RST_BIT];
         state_reg.rdy_d <= crr_pkg::STATUS_RESET[crr_pkg::ST_RDY_BIT];
         state_reg.pin_func <= crr_pkg::PIN_FUNC_RESET;
         state_reg.irq_status <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign apb_rsp.pready = (state_reg.bus == BUS_DONE);
   assign apb_rsp.prdata = state_reg.rdata;
   assign apb_rsp.pslverr = state_reg.slverr & (state_reg.bus == BUS_DONE);
   assign filter_reset = state_reg.frst;
   assign irq = |(state_reg.irq_status & state_reg.irq_mask);
endmodule : crr_result_regs

// ==== crr_result_regs_asserts.sv ====
// checker: bus timing, pulse, interrupt and pin-priority properties of the result bank
`timescale 1ns/1ps
module crr_result_regs_asserts (
   input wire logic clock, // clock
   input wire logic rst_n, // reset, active low
   input wire crr_pkg::crr_apb_req_t apb_req, // apb request
   input wire crr_pkg::crr_apb_rsp_t apb_rsp, // apb response
   input wire crr_pkg::crr_conv_t conv, // conversion strobe
   input wire logic conv_ready, // ready level
   input wire logic [crr_pkg::ERR_W-1:0] error_flags, // raw errors
   input wire logic reset_event, // reset pulse
   input wire logic [crr_pkg::GPIO_W-1:0] other_pin_oe, // other owner
   input wire logic [crr_pkg::GPIO_W-1:0] other_pin_out, // other level
   input wire logic [crr_pkg::CH_W-1:0] current_channel, // channel
   input wire logic filter_reset, // filter reset pulse
   input wire logic [crr_pkg::GPIO_W-1:0] gpio_out, // pin levels
   input wire logic [crr_pkg::GPIO_W-1:0] gpio_oe, // pin enables
   input wire logic irq // interrupt
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   logic pf_wr;
   logic rd_acc;
   logic irq_src;
   assign pf_wr = apb_rsp.pready && apb_req.pwrite && apb_req.paddr == crr_pkg::OFF_PIN_FUNCTION;
   assign rd_acc = apb_req.psel && apb_req.penable && !apb_req.pwrite;
   // any of these may set a status bit or unmask one
   assign irq_src = conv.valid || reset_event || (|error_flags)
      || (apb_req.psel && apb_req.penable && apb_req.pwrite);
   chk_one_wait: assert property (apb_req.psel && !apb_req.penable
      |=> !apb_rsp.pready ##1 apb_rsp.pready) else $error("ready not two cycles after setup");
   chk_ready_single: assert property (apb_rsp.pready |=> !apb_rsp.pready)
      else $error("ready held longer than one cycle");
   chk_err_ready: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
      else $error("slave error without ready");
   chk_pf_pulse: assert property (pf_wr |-> filter_reset)
      else $error("pin-function write gave no filter reset");
   chk_pulse_cause: assert property (filter_reset |-> pf_wr)
      else $error("filter reset without pin-function write");
   chk_owner_oe: assert property ($past(rst_n) |->
      (gpio_oe & $past(other_pin_oe)) == $past(other_pin_oe)) else $error("other owner lost pin");
   chk_owner_level: assert property ($past(rst_n) |-> (gpio_out & $past(other_pin_oe))
      == ($past(other_pin_out) & $past(other_pin_oe))) else $error("other owner level lost");
   chk_rdata_hold: assert property ($past(rst_n) && $changed(apb_rsp.prdata)
      |-> $past(rd_acc)) else $error("read data moved without a read");
   chk_irq_cause: assert property ($rose(irq) |-> $past(irq_src))
      else $error("interrupt rose without cause");
   chk_quiet_reset: assert property ($rose(rst_n) |-> !irq && gpio_oe == '0
      && !apb_rsp.pready && !filter_reset) else $error("outputs active after reset");
   cover property (pf_wr);
   cover property ($rose(irq));
   cover property (apb_rsp.pslverr);
   cover property (gpio_oe != '0 && gpio_oe != other_pin_oe);
endmodule : crr_result_regs_asserts

bind crr_result_regs crr_result_regs_asserts u_chk (.clock, .rst_n, .apb_req, .apb_rsp, .conv,
   .conv_ready, .error_flags, .reset_event, .other_pin_oe, .other_pin_out, .current_channel,
   .filter_reset, .gpio_out, .gpio_oe, .irq);

// ==== crr_host_model.sv ====
// host-side apb master model that reaches the register bank
`timescale 1ns/1ps
module crr_host_model (
   input wire logic clock, // bus clock
   output crr_pkg::crr_apb_req_t apb_req, // request to the bank
   input wire crr_pkg::crr_apb_rsp_t apb_rsp // response from the bank
);
   initial apb_req = '0;
   // call just after a rising edge; ends one idle cycle after the transfer
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic err);
      apb_req.paddr <= a;
      apb_req.pwrite <= wr;
      apb_req.pwdata <= d;
      apb_req.psel <= 1'b1;
      apb_req.penable <= 1'b0;
      @(posedge clock);
      apb_req.penable <= 1'b1;
      // the answer is taken at the rising edge where ready is sampled high, never earlier
      do begin
         @(posedge clock);
      end while (apb_rsp.pready !== 1'b1);
      q = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
      // one idle edge so a following call never raises psel in the step that lowered it
      @(posedge clock);
   endtask : xfer
endmodule : crr_host_model

// ==== crr_result_regs_tb.sv ====
// bench: register traffic, conversions, interrupts and pin checks on the result bank
`timescale 1ns/1ps
module crr_result_regs_tb;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   crr_pkg::crr_apb_req_t apb_req;
   crr_pkg::crr_apb_rsp_t apb_rsp;
   crr_pkg::crr_conv_t conv = '0;
   logic conv_ready = 1'b1;
   logic [7:0] error_flags = '0;
   logic reset_event = 1'b0;
   logic [3:0] other_pin_oe = '0;
   logic [3:0] other_pin_out = '0;
   logic [3:0] current_channel = '0;
   logic filter_reset;
   logic irq;
   logic [3:0] gpio_out;
   logic [3:0] gpio_oe;
   int n_errors = 0;
   int total_checks = 0;
   int n_frst = 0;
   always #2.5 clock = ~clock;
   // counts filter reset pulses so the bench sees every pin-function write land
   always @(posedge clock) begin
      if (filter_reset === 1'b1) begin
         n_frst <= n_frst + 1;
      end
   end
   crr_host_model host (.clock, .apb_req, .apb_rsp);
   crr_result_regs uut (.clock, .rst_n, .apb_req, .apb_rsp, .conv, .conv_ready, .error_flags,
      .reset_event, .other_pin_oe, .other_pin_out, .current_channel, .filter_reset,
      .gpio_out, .gpio_oe, .irq);
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      host.xfer(1'b1, a, d, q, e);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      logic e;
      host.xfer(1'b0, a, 32'h0, q, e);
      check(q, exp);
   endtask : rd
   task automatic irq_is(input logic v);
      @(negedge clock);
      check({31'h0, irq}, {31'h0, v});
      @(posedge clock);
   endtask : irq_is
   // only driven pins carry a meaningful level
   task automatic pins(input logic [3:0] oe, input logic [3:0] lvl);
      repeat (2) @(posedge clock);
      @(negedge clock);
      check({24'h0, gpio_oe, gpio_out & gpio_oe}, {24'h0, oe, lvl});
      @(posedge clock);
   endtask : pins
   task automatic convert(input logic [3:0] ch, input logic [23:0] d, input logic s);
      conv <= '{valid: 1'b1, channel: ch, data: d, settled: s};
      @(posedge clock);
      conv.valid <= 1'b0;
      @(posedge clock);
   endtask : convert
   task automatic print_verdict();
      if (n_errors == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : print_verdict
   initial begin
      repeat (20000) @(posedge clock);
      n_errors++;
      print_verdict();
   end
   initial begin
      logic [31:0] q;
      logic e;
      repeat (8) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      rd(8'h20, 32'h60);
      rd(8'h68, 32'h4);
      rd(8'h28, 32'h0);
      rd(8'h64, 32'h0);
      wr(8'h20, 32'hffff_ff40);
      rd(8'h20, 32'h20);
      wr(8'h28, 32'h00ab_cdef);
      rd(8'h28, 32'h0);
      host.xfer(1'b0, 8'h04, 32'h0, q, e);
      check({31'h0, e}, 32'h1);
      wr(8'h78, 32'h3);
      reset_event <= 1'b1;
      @(posedge clock);
      reset_event <= 1'b0;
      @(posedge clock);
      irq_is(1'b1);
      rd(8'h20, 32'h60);
      wr(8'h74, 32'h7);
      irq_is(1'b0);
      wr(8'h70, 32'h3);
      for (int i = 0; i < 16; i++) begin
         convert(i[3:0], {8'h5a, i[3:0], 12'hc3c}, 1'b0);
      end
      irq_is(1'b1);
      for (int i = 0; i < 16; i++) begin
         rd({i[5:0], 2'b00} + 8'h28, {8'h0, 8'h5a, i[3:0], 12'hc3c});
      end
      rd(8'h20, {8'h5a, 4'hf, 12'hc3c, 8'h7f});
      wr(8'h78, 32'h0);
      irq_is(1'b0);
      wr(8'h70, 32'h7);
      convert(4'h3, 24'h123456, 1'b0);
      rd(8'h20, 32'h1234_5663);
      convert(4'h5, 24'h654321, 1'b1);
      rd(8'h20, 32'h6543_2175);
      wr(8'h70, 32'h2);
      convert(4'h1, 24'h0f0f0f, 1'b1);
      rd(8'h20, 32'h71);
      rd(8'h2c, 32'h0f0f0f);
      wr(8'h7c, 32'h1);
      error_flags <= 8'h02;
      rd(8'h20, 32'h71);
      error_flags <= 8'h01;
      rd(8'h20, 32'hf1);
      error_flags <= 8'h00;
      conv_ready <= 1'b0;
      rd(8'h20, 32'h51);
      current_channel <= 4'ha;
      wr(8'h68, 32'hffff_ffff);
      rd(8'h68, 32'h40ff);
      pins(4'hf, 4'ha);
      other_pin_oe <= 4'h1;
      other_pin_out <= 4'h1;
      pins(4'hf, 4'hb);
      wr(8'h68, 32'h4);
      pins(4'h1, 4'h1);
      check(n_frst, 32'h2);
      wr(8'h70, 32'h8);
      rd(8'h20, 32'h6543_2151);
      print_verdict();
   end
endmodule : crr_result_regs_tb
